// ---- logic/prefetch_queue_bus_interface.sv ----
// split front end: bus interface engine with prefetch queue, plus execution engine register file
// assumes the system bus answers each cycle with a one-cycle bus_ack from logic on sys_clk
`timescale 1ns/10ps
// Functional notes
// RQ1: queue holds four bytes narrow, six bytes wide.
// RQ2: narrow: fetch a byte when one byte free and no engine request.
// RQ3: wide: fetch only with two bytes free and no engine request.
// RQ4: wide fetches bring a word from an even address.
// RQ5: odd target: fetch one byte, then words from even addresses.
// RQ6: control transfer flushes queue, fetches new address, refills.
// RQ7: engine request pauses prefetch; running prefetch completes first.
// RQ8: execution engine reaches the bus only through bus interface engine.
// RQ9: 16-bit engine addresses relocated into the megabyte space.
// RQ10: queue holds bytes at consecutive higher addresses.
// RQ11: engine data paths and registers are 16 bits; flags kept.
// RQ12: eight 16-bit general registers, four data, four pointer/index.
// RQ13: data registers split into byte halves; others word only.
// RQ14: shift count comes from count low byte.
// RQ15: accumulator low byte is implicit operand for byte I/O.
// RQ16: four segment bases; instruction fetches use the code base.
// RQ17: segment bases readable and writable by instructions.
// RQ18: next fetch offset corrected to next instruction when pushed.
// RQ19: empty queue stalls execution engine.
// RQ20: flush discards bytes of an in-flight prefetch.
module prefetch_queue_bus_interface
  import prefetch_pkg::*;
#(
  parameter bit WIDE_BUS = 1'b1
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // execution engine side
  input wire logic q_take,
  input wire logic jump_valid,
  input wire logic [15:0] jump_offset,
  input wire prefetch_pkg::eng_req_t eng_req,
  input wire prefetch_pkg::gpr_wr_t gpr_wr,
  input wire logic seg_we,
  input wire logic [1:0] seg_sel,
  input wire logic [15:0] seg_wdata,
  input wire logic [2:0] gpr_rd_index,
  input wire logic push_ip,
  input wire logic [15:0] flags_in,
  input wire logic flags_we,
  output logic q_valid,
  output logic [7:0] q_byte,
  output logic eng_done,
  output logic [15:0] eng_rdata,
  output logic [15:0] gpr_rdata,
  output logic [15:0] seg_rdata,
  output logic [7:0] shift_count,
  output logic [7:0] accum_low_byte,
  output logic [15:0] pushed_offset,
  output logic [15:0] flags_q,
  // system bus side
  output prefetch_pkg::bus_req_t bus_req,
  input wire logic bus_ack,
  input wire logic [15:0] bus_rdata
);
  import prefetch_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_FETCH = 3'b010,
    ST_ENG = 3'b100
  } bus_state_t;

  localparam logic [3:0] QCAP = WIDE_BUS ? 4'(QUEUE_WIDE) : 4'(QUEUE_NARROW);
  localparam logic [3:0] FREE_NEED = WIDE_BUS ? 4'(WORD_FREE_MIN) : 4'(BYTE_FREE_MIN);

  function automatic logic [19:0] relocate(input logic [15:0] base, input logic [15:0] off);
    relocate = 20'({base, CNT_ZERO}) + 20'(off);
  endfunction

  bus_state_t state_q;
  logic [7:0] qmem_q [QUEUE_MAX];
  logic [2:0] rd_ptr_q;
  logic [2:0] wr_ptr_q;
  logic [3:0] count_q;
  logic [15:0] next_fetch_offset_q;
  logic [15:0] seg_q [4];
  logic [15:0] gpr_q [8];
  logic fetch_word_q;
  logic flush_pend_q;
  logic [3:0] free_bytes;
  logic start_fetch;
  logic fetch_done;
  logic take_ok;
  logic fetch_odd;

  function automatic logic [2:0] ptr_inc(input logic [2:0] p, input logic [3:0] n);
    logic [3:0] s;
    s = 4'(p) + n;
    if (s >= QCAP) begin
      s = s - QCAP;
    end
    ptr_inc = s[2:0];
  endfunction

  // ------------------------------------------------------------
  // fetch decision
  // ------------------------------------------------------------
  assign free_bytes = QCAP - count_q; // RQ1
  assign fetch_odd = next_fetch_offset_q[0];
  assign take_ok = q_take && count_q != CNT_ZERO && !jump_valid; // RQ19
  // engine requests win over prefetch whenever the bus is idle
  assign start_fetch = state_q == ST_IDLE && !eng_req.valid && !jump_valid
    && free_bytes >= FREE_NEED; // RQ2 RQ3 RQ7
  assign fetch_done = state_q == ST_FETCH && bus_ack;

  // ------------------------------------------------------------
  // bus sequencer
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= ST_IDLE;
      bus_req <= '0;
      fetch_word_q <= 1'b0;
      eng_done <= 1'b0;
      eng_rdata <= WORD_ZERO;
    end else begin
      eng_done <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          if (eng_req.valid) begin // RQ8
            state_q <= ST_ENG;
            bus_req <= '{valid: 1'b1, write: eng_req.write, io: eng_req.io, word: eng_req.word,
              addr: eng_req.io ? 20'(eng_req.offset) : relocate(seg_q[eng_req.seg], eng_req.offset),
              wdata: eng_req.wdata}; // RQ9
          end else if (start_fetch) begin
            state_q <= ST_FETCH;
            // odd start is a lone byte, then aligned words follow
            fetch_word_q <= WIDE_BUS && !fetch_odd; // RQ4 RQ5
            bus_req <= '{valid: 1'b1, write: 1'b0, io: 1'b0, word: WIDE_BUS && !fetch_odd,
              addr: relocate(seg_q[SEG_CODE], next_fetch_offset_q), wdata: WORD_ZERO}; // RQ16
          end
        end
        ST_FETCH: begin
          // a running prefetch always completes before an engine request
          if (bus_ack) begin // RQ7
            state_q <= ST_IDLE;
            bus_req <= '0;
          end
        end
        ST_ENG: begin
          if (bus_ack) begin
            state_q <= ST_IDLE;
            bus_req <= '0;
            eng_done <= 1'b1;
            eng_rdata <= bus_rdata;
          end
        end
        default: begin
          state_q <= ST_IDLE;
          bus_req <= '0;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // flush tracking
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      flush_pend_q <= 1'b0;
    end else if (jump_valid && state_q == ST_FETCH && !bus_ack) begin
      flush_pend_q <= 1'b1; // RQ20
    end else if (fetch_done) begin
      flush_pend_q <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // queue and fetch offset
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rd_ptr_q <= 3'h0;
      wr_ptr_q <= 3'h0;
      count_q <= CNT_ZERO;
      next_fetch_offset_q <= WORD_ZERO;
    end else if (jump_valid) begin
      // flush; the queue empties and the next fetch starts at the jump target
      rd_ptr_q <= 3'h0; // RQ6
      wr_ptr_q <= 3'h0;
      count_q <= CNT_ZERO;
      next_fetch_offset_q <= jump_offset;
    end else begin
      if (fetch_done && !flush_pend_q) begin
        qmem_q[wr_ptr_q] <= fetch_odd || !fetch_word_q ? bus_rdata[7:0] : bus_rdata[7:0]; // RQ10
        if (fetch_word_q) begin
          qmem_q[ptr_inc(wr_ptr_q, CNT_ONE)] <= bus_rdata[15:8]; // RQ10
        end
        wr_ptr_q <= ptr_inc(wr_ptr_q, fetch_word_q ? CNT_TWO : CNT_ONE);
        next_fetch_offset_q <= next_fetch_offset_q + (fetch_word_q ? 16'h0002 : 16'h0001);
      end
      if (take_ok) begin
        rd_ptr_q <= ptr_inc(rd_ptr_q, CNT_ONE);
      end
      count_q <= count_q + ((fetch_done && !flush_pend_q) ? (fetch_word_q ? CNT_TWO : CNT_ONE) : CNT_ZERO)
        - (take_ok ? CNT_ONE : CNT_ZERO);
    end
  end

  // ------------------------------------------------------------
  // queue output to the execution engine
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      q_valid <= 1'b0;
      q_byte <= 8'h00;
    end else begin
      q_valid <= count_q != CNT_ZERO && !jump_valid && !(take_ok && count_q == CNT_ONE); // RQ19
      q_byte <= take_ok ? qmem_q[ptr_inc(rd_ptr_q, CNT_ONE)] : qmem_q[rd_ptr_q];
    end
  end

  // ------------------------------------------------------------
  // registers: general, segment, flags
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < 8; i++) begin
        gpr_q[i] <= WORD_ZERO; // RQ12
      end
    end else if (gpr_wr.we) begin
      // byte writes reach only the four data registers
      if (gpr_wr.byte_sel && !gpr_wr.index[2]) begin // RQ13
        if (gpr_wr.high_half) begin
          gpr_q[gpr_wr.index][15:8] <= gpr_wr.wdata[7:0];
        end else begin
          gpr_q[gpr_wr.index][7:0] <= gpr_wr.wdata[7:0];
        end
      end else if (!gpr_wr.byte_sel) begin
        gpr_q[gpr_wr.index] <= gpr_wr.wdata; // RQ11
      end
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      seg_q[SEG_CODE] <= CODE_BASE_RESET;
      seg_q[SEG_STACK] <= WORD_ZERO;
      seg_q[SEG_DATA] <= WORD_ZERO;
      seg_q[SEG_EXTRA] <= WORD_ZERO;
    end else if (seg_we) begin
      seg_q[seg_sel] <= seg_wdata; // RQ17
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      flags_q <= WORD_ZERO;
      gpr_rdata <= WORD_ZERO;
      seg_rdata <= WORD_ZERO;
      shift_count <= 8'h00;
      accum_low_byte <= 8'h00;
      pushed_offset <= WORD_ZERO;
    end else begin
      if (flags_we) begin
        flags_q <= flags_in; // RQ11
      end
      gpr_rdata <= gpr_q[gpr_rd_index];
      seg_rdata <= seg_q[seg_sel]; // RQ17
      shift_count <= gpr_q[REG_COUNT][7:0]; // RQ14
      accum_low_byte <= gpr_q[REG_ACCUM][7:0]; // RQ15
      // fetch offset runs ahead by the bytes still queued
      if (push_ip) begin
        pushed_offset <= next_fetch_offset_q - 16'(count_q); // RQ18
      end
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  queue_bound_a: assert property (@(posedge sys_clk) disable iff (!reset_n) count_q <= QCAP) // RQ1
    else $error("queue over capacity");
  fetch_room_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    $rose(state_q == ST_FETCH) |-> $past(free_bytes) >= FREE_NEED) // RQ2 RQ3
    else $error("fetch started without room");
  word_even_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    bus_req.valid && state_q == ST_FETCH && bus_req.word |-> !bus_req.addr[0]) // RQ4
    else $error("word fetch misaligned");
  fetch_hold_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    state_q == ST_FETCH && !bus_ack |=> state_q == ST_FETCH) // RQ7
    else $error("prefetch abandoned");
  flush_empty_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    jump_valid |=> count_q == CNT_ZERO && !q_valid) // RQ6
    else $error("queue not flushed");
  stale_drop_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    flush_pend_q && fetch_done |=> count_q == CNT_ZERO || $past(jump_valid)) // RQ20
    else $error("stale fetch kept");
  empty_stall_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    count_q == CNT_ZERO |=> !q_valid) // RQ19
    else $error("byte offered from empty queue");
  eng_served_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    state_q == ST_ENG && bus_ack |=> eng_done && eng_rdata == $past(bus_rdata)) // RQ8
    else $error("engine request not answered");
endmodule // prefetch_queue_bus_interface

// ---- logic/prefetch_pkg.sv ----
// shared constants and carriers for the prefetch queue and bus interface engine
// assumes a single processor clock and a simple request/acknowledge system bus
package prefetch_pkg;
  localparam int QUEUE_NARROW = 4;
  localparam int QUEUE_WIDE = 6;
  localparam int QUEUE_MAX = 6;
  localparam int WORD_FREE_MIN = 2;
  localparam int BYTE_FREE_MIN = 1;
  localparam logic [3:0] SEG_SHIFT = 4'h4;
  localparam logic [3:0] CNT_ZERO = 4'h0;
  localparam logic [3:0] CNT_ONE = 4'h1;
  localparam logic [3:0] CNT_TWO = 4'h2;
  localparam logic [15:0] WORD_ZERO = 16'h0000;
  localparam logic [19:0] ADDR_ZERO = 20'h0_0000;
  localparam logic [15:0] CODE_BASE_RESET = 16'hFFFF;
  localparam logic [1:0] SEG_CODE = 2'h0;
  localparam logic [1:0] SEG_STACK = 2'h1;
  localparam logic [1:0] SEG_DATA = 2'h2;
  localparam logic [1:0] SEG_EXTRA = 2'h3;
  localparam logic [2:0] REG_ACCUM = 3'h0;
  localparam logic [2:0] REG_COUNT = 3'h1;

  // execution engine request to the bus interface engine
  typedef struct packed {
    logic valid;
    logic write;
    logic io;
    logic word;
    logic [1:0] seg;
    logic [15:0] offset;
    logic [15:0] wdata;
  } eng_req_t;

  // system bus cycle request
  typedef struct packed {
    logic valid;
    logic write;
    logic io;
    logic word;
    logic [19:0] addr;
    logic [15:0] wdata;
  } bus_req_t;

  // general register file access
  typedef struct packed {
    logic we;
    logic byte_sel;
    logic high_half;
    logic [2:0] index;
    logic [15:0] wdata;
  } gpr_wr_t;
endpackage

// ---- tb/bus_memory_model.sv ----
// memory and I/O devices on the system bus, answering the bus interface engine
// assumes bus_req is registered on sys_clk and held until the edge after bus_ack
`timescale 1ns/10ps
module bus_memory_model
  import prefetch_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // system bus
  input wire prefetch_pkg::bus_req_t bus_req,
  input wire logic slow,
  output logic bus_ack,
  output logic [15:0] bus_rdata
);
  int wait_n;

  // every byte location holds a value derived from its own address
  function automatic logic [7:0] mem_byte(logic [19:0] a);
    return a[7:0] ^ {a[19:16], a[11:8]};
  endfunction

  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      bus_ack <= 1'b0;
      bus_rdata <= 16'h0000;
      wait_n <= 0;
    end else if (bus_ack) begin
      bus_ack <= 1'b0;
      // released data lines must not keep showing the last value
      bus_rdata <= ~bus_rdata;
    end else if (bus_req.valid) begin
      if (wait_n == 1) begin
        bus_ack <= 1'b1;
        // lower address byte on the low lane
        bus_rdata <= bus_req.word ? {mem_byte(bus_req.addr + 20'h0_0001), mem_byte(bus_req.addr)}
                                  : {2{mem_byte(bus_req.addr)}};
      end
      wait_n <= (wait_n == 0) ? (slow ? 6 : $urandom_range(1, 3)) : wait_n - 1;
    end
  end
endmodule // bus_memory_model

// ---- tb/prefetch_queue_bus_interface_tb.sv ----
// self-checking bench for the prefetch queue and bus interface engine
// assumes bus_memory_model answers the system bus; wide build checked in full, narrow build on fill and its first refill only
`timescale 1ns/10ps
module prefetch_queue_bus_interface_tb;
  import prefetch_pkg::*;
  logic sys_clk, reset_n, q_take, jump_valid, seg_we, push_ip, flags_we, slow, go, v_q, a_q;
  logic q_valid, eng_done, bus_ack;
  logic [1:0] seg_sel;
  logic [2:0] gpr_rd_index;
  logic [7:0] q_byte, shift_count, accum_low_byte;
  logic [15:0] jump_offset, seg_wdata, flags_in, eng_rdata, gpr_rdata, seg_rdata;
  logic [15:0] pushed_offset, flags_q, bus_rdata;
  logic [15:0] sb [4];
  logic [15:0] rv [8];
  logic [19:0] pos, ea;
  logic [22:0] start_q [$];
  eng_req_t eng_req;
  gpr_wr_t gpr_wr;
  bus_req_t bus_req;
  int mismatches, n_tests, n0;
  // narrow build shares every input except its own bus
  logic nbus_ack, nv_q;
  logic [7:0] nq_byte;
  logic [15:0] nbus_rdata;
  logic [22:0] nfirst;
  bus_req_t nbus_req;
  int nstarts;

  prefetch_queue_bus_interface #(.WIDE_BUS(1'b1)) prefetch_queue_bus_interface_inst (
    .sys_clk, .reset_n, .q_take, .jump_valid, .jump_offset, .eng_req, .gpr_wr, .seg_we, .seg_sel,
    .seg_wdata, .gpr_rd_index, .push_ip, .flags_in, .flags_we, .q_valid, .q_byte, .eng_done,
    .eng_rdata, .gpr_rdata, .seg_rdata, .shift_count, .accum_low_byte, .pushed_offset, .flags_q,
    .bus_req, .bus_ack, .bus_rdata);
  bus_memory_model bus_memory_model_inst (.sys_clk, .reset_n, .bus_req, .slow, .bus_ack, .bus_rdata);
  prefetch_queue_bus_interface #(.WIDE_BUS(1'b0)) prefetch_queue_bus_interface_narrow_inst (
    .sys_clk, .reset_n, .q_take, .jump_valid, .jump_offset, .eng_req, .gpr_wr, .seg_we, .seg_sel,
    .seg_wdata, .gpr_rd_index, .push_ip, .flags_in, .flags_we, .q_valid(), .q_byte(nq_byte), .eng_done(),
    .eng_rdata(), .gpr_rdata(), .seg_rdata(), .shift_count(), .accum_low_byte(), .pushed_offset(), .flags_q(),
    .bus_req(nbus_req), .bus_ack(nbus_ack), .bus_rdata(nbus_rdata));
  bus_memory_model bus_memory_model_narrow_inst (.sys_clk, .reset_n, .bus_req(nbus_req), .slow,
    .bus_ack(nbus_ack), .bus_rdata(nbus_rdata));

  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  // record {write, io, word, addr} of every bus cycle start
  always @(posedge sys_clk) begin
    if (bus_req.valid && (!v_q || a_q)) start_q.push_back({bus_req.write, bus_req.io, bus_req.word, bus_req.addr});
    v_q <= bus_req.valid;
    a_q <= bus_ack;
  end

  // narrow bus cycles never run back to back, so a rise of valid is a start
  always @(posedge sys_clk) begin
    if (nbus_req.valid && !nv_q && nstarts == 0) nfirst <= {nbus_req.write, nbus_req.io, nbus_req.word, nbus_req.addr};
    if (nbus_req.valid && !nv_q) nstarts++;
    nv_q <= nbus_req.valid;
  end

  // ---------------------------------------------------------------
  // reference helpers
  // ---------------------------------------------------------------
  function automatic logic [7:0] mb(logic [19:0] a);
    return a[7:0] ^ {a[19:16], a[11:8]};
  endfunction
  function automatic logic [19:0] lin(logic [15:0] b, logic [15:0] o);
    return {b, 4'h0} + {4'h0, o};
  endfunction
  task automatic check(string what, logic [22:0] seen, logic [22:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic step(int n);
    repeat (n) @(negedge sys_clk);
  endtask
  task automatic tally_and_finish;
    $display("mismatches %0d of %0d checks", mismatches, n_tests);
    if (mismatches == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // take n bytes at random pace; q_take held high across back-to-back takes
  task automatic consume(int n);
    int i = 0;
    for (int k = 0; k < 500 && i < n; k++) begin
      step(1);
      go = q_valid === 1'b1 && $urandom_range(0, 3) != 0;
      if (go) begin
        check("q_byte", q_byte, mb(pos));
        pos = pos + 20'h0_0001;
        i++;
      end
      q_take = go;
    end
    step(1);
    q_take = 1'b0;
    check("taken", i, n);
  endtask
  task automatic seg_write(logic [1:0] s, logic [15:0] d);
    seg_sel = s;
    seg_wdata = d;
    seg_we = 1'b1;
    step(1);
    seg_we = 1'b0;
    sb[s] = d;
    step(1);
    check("seg_base", seg_rdata, d);
  endtask
  task automatic gpr_write(logic bsel, logic hi, logic [2:0] idx, logic [15:0] d);
    gpr_wr = '{1'b1, bsel, hi, idx, d};
    step(1);
    gpr_wr.we = 1'b0;
    if (!bsel) rv[idx] = d;
    else if (idx < 3'h4 && hi) rv[idx][15:8] = d[7:0];
    else if (idx < 3'h4) rv[idx][7:0] = d[7:0];
    step(1);
  endtask
  task automatic gpr_check;
    for (int i = 0; i < 8; i++) begin
      gpr_rd_index = i[2:0];
      step(2);
      check("gpr", gpr_rdata, rv[i]);
    end
    check("shift_count", shift_count, rv[REG_COUNT][7:0]);
    check("accum_low", accum_low_byte, rv[REG_ACCUM][7:0]);
  endtask
  task automatic eng_op(logic wr, logic io, logic [1:0] s, logic [15:0] off);
    int n;
    logic [19:0] a;
    n = start_q.size();
    a = io ? {4'h0, off} : lin(sb[s], off);
    eng_req = '{1'b1, wr, io, 1'b1, s, off, off ^ 16'hA5A5};
    for (int k = 0; k < 100 && eng_done !== 1'b1; k++) step(1);
    check("eng_done", eng_done, 1'b1);
    if (!wr) check("eng_rdata", eng_rdata, {mb(a + 20'h0_0001), mb(a)});
    eng_req.valid = 1'b0;
    check("eng_cycle", start_q[$], {wr, io, 1'b1, a});
    check("ahead", start_q.size() - n <= 2, 1'b1);
    step(1);
  endtask

  initial begin
    repeat (30000) @(posedge sys_clk);
    mismatches++;
    tally_and_finish;
  end

  initial begin
    void'($urandom(82));
    {q_take, jump_valid, seg_we, push_ip, flags_we, slow} = '0;
    {jump_offset, seg_wdata, flags_in, seg_sel, gpr_rd_index} = '0;
    eng_req = '0;
    gpr_wr = '0;
    reset_n = 1'b0;
    pos = lin(CODE_BASE_RESET, WORD_ZERO);
    step(4);
    reset_n = 1'b1;
    step(60);
    check("fill", start_q.size(), 3);
    check("first", start_q[0], {3'b001, pos});
    check("narrow_fill", nstarts, 4);
    check("narrow_first", nfirst, {3'b000, pos});
    check("narrow_head", nq_byte, mb(pos));
    consume(1);
    step(30);
    check("one_free", start_q.size(), 3);
    check("narrow_refill", nstarts, 5);
    consume(1);
    step(30);
    check("two_free", start_q.size(), 4);
    consume(4);
    step(40);
    for (int s = 0; s < 4; s++) seg_write(s[1:0], 16'($urandom));
    // slow memory keeps a prefetch in flight across the jump
    slow = 1'b1;
    consume(2);
    // let the refill fetch launch so the jump lands while it is outstanding
    step(3);
    jump_offset = 16'($urandom) | 16'h0001;
    jump_valid = 1'b1;
    step(1);
    jump_valid = 1'b0;
    n0 = start_q.size();
    step(2);
    check("flushed", q_valid, 1'b0);
    pos = lin(sb[SEG_CODE], jump_offset);
    ea = pos;
    consume(5);
    check("odd_first", start_q[n0], {3'b000, ea});
    check("even_next", start_q[n0 + 1], {3'b001, ea + 20'h0_0001});
    push_ip = 1'b1;
    step(1);
    push_ip = 1'b0;
    step(1);
    check("pushed", pushed_offset, 16'(jump_offset + 16'h0005));
    slow = 1'b0;
    for (int i = 0; i < 4; i++) eng_op(i[0], i[1], 2'($urandom_range(1, 3)), 16'($urandom) & 16'hFFFE);
    for (int i = 0; i < 8; i++) gpr_write(1'b0, 1'b0, i[2:0], 16'($urandom));
    gpr_check;
    gpr_write(1'b1, 1'b0, REG_COUNT, 16'($urandom));
    gpr_write(1'b1, 1'b1, REG_ACCUM, 16'($urandom));
    gpr_write(1'b1, 1'b0, 3'h5, 16'($urandom));
    gpr_check;
    flags_in = 16'($urandom);
    flags_we = 1'b1;
    step(1);
    flags_we = 1'b0;
    step(1);
    check("flags", flags_q, flags_in);
    tally_and_finish;
  end
endmodule // prefetch_queue_bus_interface_tb
